// [hdl/flash_protect_pkg.sv]
// Constants, types and register map for the flash sector write-protection block
// Function
// - Bottom-select 0: range code protects upper fraction
// - Bottom-select 1: same sizes from lowest address
// - Sector protected if range or per-sector protects
// - Config bit 0 locks range code, select
// - Lock-settings bit sticks until power-on reset
// - Lock-settings bit blocks one-time area programming
// - Locked range-code write ignored, no error
// - Either sector bit zero blocks program, erase
// - Nv lock zero refuses nv-bit program/erase, fails
// - Persistent: reset sets lock, only clearable
// - Password: reset clears lock, command clears too
// - Password: exact 64-bit match sets lock
// - Mode bits: 11 default, 10 persistent, 01 password
// - Programming mode bits to 00 fails
// - Selected mode freezes protection config register
// - Config programming busy shows write-in-progress
// - Unconfigured: persistent mode, all sectors unprotected
// - Nv bits programmed singly, erased together, verified
// - Volatile bit matters only when nv bit one
// - Volatile write clears or sets addressed bit
// - Volatile bits reset unprotected; read 00h/FFh
package flash_protect_pkg;
   // Geometry
   localparam int SECTOR_BITS = 6;                   // Sector index width
   localparam int SECTORS     = 64;                  // Sector count
   // Register byte offsets
   localparam logic [7:0] ADR_CTRL    = 8'h00;       // Range code, select, lock-settings
   localparam logic [7:0] ADR_MODE    = 8'h04;       // Protection config register
   localparam logic [7:0] ADR_CMD     = 8'h08;       // Command and sector
   localparam logic [7:0] ADR_STATUS  = 8'h0C;       // Status
   localparam logic [7:0] ADR_PWLO    = 8'h10;       // Password word low
   localparam logic [7:0] ADR_PWHI    = 8'h14;       // Password word high
   localparam logic [7:0] ADR_VREAD   = 8'h18;       // Volatile access byte of sector
   localparam logic [7:0] ADR_NVREAD  = 8'h1C;       // Nonvolatile access byte of sector
   localparam logic [7:0] ADR_PROTLO  = 8'h20;       // Effective protection, sectors 0-31
   localparam logic [7:0] ADR_PROTHI  = 8'h24;       // Effective protection, sectors 32-63
   // Control fields
   localparam int CTRL_LOCK_POS  = 0;                // Lock-settings bit
   localparam int CTRL_TB_POS    = 1;                // Top-bottom select
   localparam int CTRL_RANGE_POS = 2;                // Range code, 3 bits
   // Mode fields
   localparam int MODE_LO_POS = 1;                   // Mode-select bits [2:1]
   localparam logic [1:0] MODE_UNSET      = 2'h3;
   localparam logic [1:0] MODE_PERSISTENT = 2'h2;
   localparam logic [1:0] MODE_PASSWORD   = 2'h1;
   localparam logic [1:0] MODE_ILLEGAL    = 2'h0;
   // Command codes, CMD bits [3:0]; sector in [13:8]
   localparam logic [3:0] CMD_WRITE_ENABLE_CMD   = 4'h1;         // Write-enable
   localparam logic [3:0] CMD_NVPROG = 4'h2;         // Program nv bit to 0
   localparam logic [3:0] CMD_NVERAS = 4'h3;         // Erase all nv bits to 1
   localparam logic [3:0] CMD_VCLR   = 4'h4;         // Volatile bit to 0
   localparam logic [3:0] CMD_VSET   = 4'h5;         // Volatile bit to 1
   localparam logic [3:0] CMD_LOCKCLR= 4'h6;         // Clear nv lock
   localparam logic [3:0] CMD_UNLOCK = 4'h7;         // Password unlock
   localparam logic [3:0] CMD_PWPROG = 4'h8;         // Program password (zeros only)
   localparam logic [3:0] CMD_OTPPROG= 4'h9;         // One-time area program
   localparam logic [3:0] CMD_ARRAY  = 4'hA;         // Array program/erase check
   localparam logic [3:0] CMD_HWRST  = 4'hF;         // Hardware reset
   localparam int CMD_SEC_POS = 8;
   // Status fields
   localparam int ST_WIP  = 0;                       // Write in progress
   localparam int ST_WEL  = 1;                       // Write-enable latch
   localparam int ST_PERR = 2;                       // Program failure
   localparam int ST_LOCK = 3;                       // Nv-bit lock
   localparam int ST_DONE = 4;                       // Last timed op completed without failure
   // Timing
   localparam int CLK_MHZ       = 40;
   localparam int T_PAGE_US     = 250;               // Page program time
   localparam int T_ERASE_US    = 500;               // Nv erase time (incl. preprogram)
   localparam int PAGE_CYC      = T_PAGE_US * CLK_MHZ;
   localparam int ERASE_CYC     = T_ERASE_US * CLK_MHZ;
   localparam int T_UNLOCK_US   = 100;               // Failed-unlock hold-off
   localparam int UNLOCK_CYC    = T_UNLOCK_US * CLK_MHZ;
   localparam logic [63:0] PW_DEFAULT = 64'hFFFF_FFFF_FFFF_FFFF;
   // Engine states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_BUSY  = 3'b010,
      ST_FIN   = 3'b100
   } eng_t;
endpackage : flash_protect_pkg

// [hdl/flash_sector_write_protection.sv]
// Sector write-protection engine with classic Wishbone register slave
module flash_sector_write_protection
   import flash_protect_pkg::*;
#(
   parameter int PAGE_CYCLES   = PAGE_CYC,           // Busy time, config/nv/password programming
   parameter int ERASE_CYCLES  = ERASE_CYC,          // Busy time, nv erase
   parameter int UNLOCK_CYCLES = UNLOCK_CYC          // Busy time after failed unlock
) (
   input  wire logic        clk,
   input  wire logic        srst,                    // Power-on reset
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             writeInProgress,         // Busy flag
   output logic             programFail              // Last op failed
);

   // Range-code protection test for one sector
   function automatic logic rangeHit(input logic [2:0] code, input logic bottom,
                                     input logic [SECTOR_BITS-1:0] sec);
      logic [SECTOR_BITS-1:0] idx;
      logic [SECTOR_BITS:0]   span;
      idx  = bottom ? sec : ~sec;                    // Distance from start edge
      span = (code == 3'h0) ? 7'h00 : (7'h01 << (code - 3'h1));
      if (code == 3'h7) begin
         rangeHit = 1'b1;                            // All sectors
      end else begin
         rangeHit = ({1'b0, idx} < span);
      end
   endfunction : rangeHit

   logic [2:0]         rangeCode;                    // Range code
   logic               topBottomSelect;              // 0 upper, 1 lower
   logic               lockSettings;                 // Freezes range settings
   logic [1:0]         modeSel;                      // Mode-select bits
   logic               nvBitLock;                    // 1 allows nv-bit change
   logic [SECTORS-1:0] nvBits;                       // Nonvolatile per-sector bits
   logic [SECTORS-1:0] volBits;                      // Volatile per-sector bits
   logic [63:0]        password;                     // Hidden password
   logic [63:0]        pwEntry;                      // Host-supplied value
   logic               write_enable_latch;                          // Write-enable latch
   logic               done;                         // Last timed op completed without failure
   logic [SECTORS-1:0] protect;                      // Effective protection
   eng_t               eng;                          // Engine state
   logic [17:0]        busyCnt;                      // Busy countdown
   logic [3:0]         pendOp;                       // Operation being timed
   logic [SECTOR_BITS-1:0] pendSec;                  // Sector of that operation
   logic [1:0]         pendMode;                     // Mode bits being programmed
   logic               pendFail;                     // Timed op ends in failure

   logic               access;                       // Bus request this cycle
   logic               wrCtrl, wrMode, wrCmd, wrPwLo, wrPwHi;
   logic [3:0]         cmdOp;
   logic [SECTOR_BITS-1:0] cmdSec;
   logic               persistentMode;

   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrCtrl = access && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0];
   assign wrMode = access && wb_we_i && wb_adr_i == ADR_MODE && wb_sel_i[0];
   assign wrCmd  = access && wb_we_i && wb_adr_i == ADR_CMD && wb_sel_i[0];
   assign wrPwLo = access && wb_we_i && wb_adr_i == ADR_PWLO && (&wb_sel_i);
   assign wrPwHi = access && wb_we_i && wb_adr_i == ADR_PWHI && (&wb_sel_i);
   assign cmdOp  = wb_dat_i[3:0];
   assign cmdSec = wb_dat_i[CMD_SEC_POS +: SECTOR_BITS];
   assign persistentMode = (modeSel != MODE_PASSWORD);

   // Effective protection per sector
   always_comb begin
      for (int i = 0; i < SECTORS; i++) begin
         protect[i] = rangeHit(rangeCode, topBottomSelect, SECTOR_BITS'(i))
                    | ~nvBits[i] | ~volBits[i];
      end
   end

   // Single-cycle ack, dropped after one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   // Read data
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (access && !wb_we_i) begin
         unique case (wb_adr_i)
            ADR_CTRL:   wb_dat_o <= {27'h0, rangeCode, topBottomSelect, lockSettings};
            ADR_MODE:   wb_dat_o <= {29'h0, modeSel, 1'b1};
            ADR_STATUS: wb_dat_o <= {27'h0, done, nvBitLock, programFail, write_enable_latch, writeInProgress};
            ADR_VREAD:  wb_dat_o <= {24'h0, {8{volBits[wb_dat_i[SECTOR_BITS-1:0]]}}};
            ADR_NVREAD: wb_dat_o <= {24'h0, {8{nvBits[wb_dat_i[SECTOR_BITS-1:0]]}}};
            ADR_PROTLO: wb_dat_o <= protect[31:0];
            ADR_PROTHI: wb_dat_o <= protect[63:32];
            default:    wb_dat_o <= 32'h0000_0000;   // Unmapped, password hidden
         endcase
      end
   end

   // Range code, select and lock-settings
   always_ff @(posedge clk) begin
      if (srst) begin
         rangeCode       <= 3'h0;
         topBottomSelect <= 1'b0;
         lockSettings    <= 1'b0;
      end else if (wrCtrl && eng == ST_IDLE) begin
         if (!lockSettings) begin
            rangeCode       <= wb_dat_i[CTRL_RANGE_POS +: 3];
            topBottomSelect <= wb_dat_i[CTRL_TB_POS];
         end
         lockSettings <= lockSettings | wb_dat_i[CTRL_LOCK_POS];
      end
   end

   // Password entry latch
   always_ff @(posedge clk) begin
      if (srst) begin
         pwEntry <= 64'h0;
      end else if (wrPwLo) begin
         pwEntry[31:0] <= wb_dat_i;
      end else if (wrPwHi) begin
         pwEntry[63:32] <= wb_dat_i;
      end
   end

   // Command engine: accepts, times and completes commands
   always_ff @(posedge clk) begin
      if (srst) begin
         eng      <= ST_IDLE;
         busyCnt  <= 18'h0;
         pendOp   <= 4'h0;
         pendSec  <= '0;
         pendMode <= MODE_UNSET;
         pendFail <= 1'b0;
      end else begin
         unique case (eng)
            ST_IDLE: begin
               if (wrMode && write_enable_latch) begin
                  pendOp   <= 4'h0;                  // Mode programming
                  pendMode <= wb_dat_i[MODE_LO_POS +: 2];
                  pendFail <= (modeSel != MODE_UNSET)
                           || wb_dat_i[MODE_LO_POS +: 2] == MODE_ILLEGAL;
                  busyCnt  <= 18'(PAGE_CYCLES - 1);
                  eng      <= ST_BUSY;
               end else if (wrCmd && write_enable_latch && cmdOp != CMD_UNLOCK) begin
                  pendOp   <= cmdOp;
                  pendSec  <= cmdSec;
                  unique case (cmdOp)
                     CMD_NVPROG: begin
                        pendFail <= !nvBitLock;
                        busyCnt  <= 18'(PAGE_CYCLES - 1);
                        eng      <= ST_BUSY;
                     end
                     CMD_NVERAS: begin
                        pendFail <= !nvBitLock;
                        busyCnt  <= 18'(ERASE_CYCLES - 1);
                        eng      <= ST_BUSY;
                     end
                     CMD_PWPROG: begin
                        pendFail <= (modeSel == MODE_PASSWORD);
                        busyCnt  <= 18'(PAGE_CYCLES - 1);
                        eng      <= ST_BUSY;
                     end
                     CMD_OTPPROG: begin
                        pendFail <= lockSettings;
                        busyCnt  <= 18'(PAGE_CYCLES - 1);
                        eng      <= ST_BUSY;
                     end
                     CMD_ARRAY: begin
                        pendFail <= protect[cmdSec];
                        busyCnt  <= 18'(PAGE_CYCLES - 1);
                        eng      <= ST_BUSY;
                     end
                     default: begin
                     end
                  endcase
               end else if (wrCmd && cmdOp == CMD_UNLOCK && modeSel == MODE_PASSWORD) begin
                  pendOp   <= CMD_UNLOCK;
                  pendFail <= (pwEntry != password);
                  busyCnt  <= (pwEntry != password) ? 18'(UNLOCK_CYCLES - 1) : 18'h0;
                  eng      <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (busyCnt == 18'h0) begin
                  eng <= ST_FIN;
               end else begin
                  busyCnt <= busyCnt - 18'h1;
               end
            end
            ST_FIN: begin
               eng <= ST_IDLE;
            end
         endcase
      end
   end

   // Mode-select bits and password storage
   always_ff @(posedge clk) begin
      if (srst) begin
         modeSel  <= MODE_UNSET;
         password <= PW_DEFAULT;
      end else if (eng == ST_FIN && !pendFail) begin
         if (pendOp == 4'h0) begin
            modeSel <= pendMode;
         end else if (pendOp == CMD_PWPROG) begin
            password <= password & pwEntry;          // Zeros only
         end
      end
   end

   // Nv-bit lock
   always_ff @(posedge clk) begin
      if (srst || (wrCmd && cmdOp == CMD_HWRST)) begin
         nvBitLock <= (modeSel != MODE_PASSWORD);
      end else if (wrCmd && cmdOp == CMD_LOCKCLR && eng == ST_IDLE) begin
         nvBitLock <= 1'b0;
      end else if (eng == ST_FIN && pendOp == CMD_UNLOCK && !pendFail) begin
         nvBitLock <= 1'b1;
      end
   end

   // Nonvolatile sector bits
   always_ff @(posedge clk) begin
      if (srst) begin
         nvBits <= {SECTORS{1'b1}};
      end else if (eng == ST_FIN && !pendFail) begin
         if (pendOp == CMD_NVPROG) begin
            nvBits[pendSec] <= 1'b0;
         end else if (pendOp == CMD_NVERAS) begin
            nvBits <= {SECTORS{1'b1}};
         end
      end
   end

   // Volatile sector bits
   always_ff @(posedge clk) begin
      if (srst || (wrCmd && cmdOp == CMD_HWRST)) begin
         volBits <= {SECTORS{1'b1}};
      end else if (wrCmd && eng == ST_IDLE) begin
         if (cmdOp == CMD_VCLR) begin
            volBits[cmdSec] <= 1'b0;
         end else if (cmdOp == CMD_VSET) begin
            volBits[cmdSec] <= 1'b1;
         end
      end
   end

   // Write-enable latch
   always_ff @(posedge clk) begin
      if (srst || (wrCmd && cmdOp == CMD_HWRST)) begin
         write_enable_latch <= 1'b0;
      end else if (wrCmd && cmdOp == CMD_WRITE_ENABLE_CMD && eng == ST_IDLE) begin
         write_enable_latch <= 1'b1;
      end else if (eng == ST_FIN && !pendFail) begin
         write_enable_latch <= 1'b0;
      end
   end

   // Busy, failure and done status
   always_ff @(posedge clk) begin
      if (srst) begin
         writeInProgress <= 1'b0;
         programFail     <= 1'b0;
         done            <= 1'b0;
      end else begin
         writeInProgress <= (eng == ST_BUSY) || (eng == ST_IDLE && access && wb_we_i
                            && ((wrMode && write_enable_latch) || (wrCmd && write_enable_latch && (cmdOp == CMD_NVPROG
                            || cmdOp == CMD_NVERAS || cmdOp == CMD_PWPROG
                            || cmdOp == CMD_OTPPROG || cmdOp == CMD_ARRAY))
                            || (wrCmd && cmdOp == CMD_UNLOCK && modeSel == MODE_PASSWORD)));
         if (eng == ST_FIN) begin
            programFail <= pendFail;
            done        <= !pendFail;
         end else if (wrCmd && cmdOp == CMD_WRITE_ENABLE_CMD) begin
            programFail <= 1'b0;
         end
      end
   end

   // Checks
   property p_lockHold;
      @(posedge clk) disable iff (srst) lockSettings |=> lockSettings && $stable(rangeCode);
   endproperty
   a_lockHold: assert property (p_lockHold) else $error("range settings changed while locked");

   property p_lockSticky;
      @(posedge clk) disable iff (srst) $rose(lockSettings) |=> lockSettings[*8];
   endproperty
   a_lockSticky: assert property (p_lockSticky) else $error("lock-settings cleared");

   property p_nvRefuse;
      @(posedge clk) disable iff (srst) !nvBitLock ##0 eng == ST_FIN && pendOp == CMD_NVPROG
         |=> $stable(nvBits) && programFail;
   endproperty
   a_nvRefuse: assert property (p_nvRefuse) else $error("nv bit changed while locked");

   property p_protOr;
      @(posedge clk) disable iff (srst) (!nvBits[0] || !volBits[0]) |-> protect[0];
   endproperty
   a_protOr: assert property (p_protOr) else $error("sector not protected");

   property p_all;
      @(posedge clk) disable iff (srst) rangeCode == 3'h7 |-> &protect;
   endproperty
   a_all: assert property (p_all) else $error("code 7 not full");

   property p_persistNoSet;
      @(posedge clk) disable iff (srst) persistentMode && !nvBitLock && !(wrCmd && cmdOp == CMD_HWRST)
         |=> !nvBitLock;
   endproperty
   a_persistNoSet: assert property (p_persistNoSet) else $error("nv lock set in persistent");

   property p_modeFreeze;
      @(posedge clk) disable iff (srst) modeSel != MODE_UNSET |=> $stable(modeSel);
   endproperty
   a_modeFreeze: assert property (p_modeFreeze) else $error("mode changed");

   property p_illegal;
      @(posedge clk) disable iff (srst) modeSel != MODE_ILLEGAL;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal mode stored");

   property p_wip;
      @(posedge clk) disable iff (srst) eng == ST_BUSY |=> writeInProgress;
   endproperty
   a_wip: assert property (p_wip) else $error("busy not shown");

   property p_bottomHalf;
      @(posedge clk) disable iff (srst) topBottomSelect && rangeCode == 3'h6 && &(nvBits & volBits)
         |-> protect == {32'h0000_0000, 32'hFFFF_FFFF};
   endproperty
   a_bottomHalf: assert property (p_bottomHalf) else $error("lower half wrong");

   property p_unlockSet;
      @(posedge clk) disable iff (srst) eng == ST_FIN && pendOp == CMD_UNLOCK && !pendFail
         && !(wrCmd && cmdOp == CMD_HWRST) |=> nvBitLock;
   endproperty
   a_unlockSet: assert property (p_unlockSet) else $error("unlock did not set lock");

   property p_otpBlock;
      @(posedge clk) disable iff (srst) wrCmd && write_enable_latch && eng == ST_IDLE && cmdOp == CMD_OTPPROG && lockSettings
         |=> pendFail;
   endproperty
   a_otpBlock: assert property (p_otpBlock) else $error("otp program not refused");

   property p_resetState;
      @(posedge clk) disable iff (srst) $past(srst) |-> &volBits && &nvBits && rangeCode == 3'h0 && nvBitLock;
   endproperty
   a_resetState: assert property (p_resetState) else $error("reset state wrong");

   property p_eraseAll;
      @(posedge clk) disable iff (srst) eng == ST_FIN && pendOp == CMD_NVERAS && !pendFail |=> &nvBits;
   endproperty
   a_eraseAll: assert property (p_eraseAll) else $error("nv bits not erased");

   property p_arrayBlock;
      @(posedge clk) disable iff (srst) wrCmd && write_enable_latch && eng == ST_IDLE && cmdOp == CMD_ARRAY && protect[cmdSec]
         |=> pendFail;
   endproperty
   a_arrayBlock: assert property (p_arrayBlock) else $error("protected sector not refused");

   c_unlock: cover property (@(posedge clk) disable iff (srst) $rose(nvBitLock));
   c_fail:   cover property (@(posedge clk) disable iff (srst) $rose(programFail));
   c_mode:   cover property (@(posedge clk) disable iff (srst) $changed(modeSel));
endmodule : flash_sector_write_protection

// [dv/host_model.sv]
// Host controller model issuing protection commands over classic Wishbone
module host_model
   import flash_protect_pkg::*;
(
   input  wire logic        clk,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dat,
   input  wire logic [31:0] rdat,
   input  wire logic        ack,
   input  wire logic        write_in_progress
);
   timeunit 1ns;
   timeprecision 1ps;
   int hung = 0;                                     // Timed-out waits
   // Bus idle at time zero
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we  = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0;
   end
   // One classic cycle, request held until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      bit ok;
      ok = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      for (int k = 0; k < 40 && !ok; k++) begin
         @(posedge clk);
         ok = ack;
      end
      q = rdat;
      if (!ok) hung++;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      adr <= ~a;                                     // Released lines show garbage
      dat <= ~d;
   endtask : xfer
   // Command with optional write-enable ahead of it
   task automatic op(input logic [3:0] o, input logic [5:0] s, input bit arm);
      logic [31:0] q;
      if (arm) xfer(1'b1, ADR_CMD, {28'h0, CMD_WRITE_ENABLE_CMD}, q);
      xfer(1'b1, ADR_CMD, {18'h0, s, 4'h0, o}, q);
   endtask : op
   // Poll busy until it drops, counting busy cycles
   task automatic wipwait(output int n);
      n = int'(write_in_progress);                                 // Busy already shown at the ack edge
      for (int k = 0; k < 100; k++) begin
         @(posedge clk);
         if (write_in_progress) n++;
         else if (n > 0 || k > 3) return;
      end
      hung++;
   endtask : wipwait
   // Password first, then the mode bits
   task automatic choose_password(input logic [63:0] pw, output int n);
      logic [31:0] q;
      xfer(1'b1, ADR_PWLO, pw[31:0], q);
      xfer(1'b1, ADR_PWHI, pw[63:32], q);
      op(CMD_PWPROG, 6'h0, 1);
      wipwait(n);
      op(CMD_WRITE_ENABLE_CMD, 6'h0, 0);
      xfer(1'b1, ADR_MODE, {29'h0, MODE_PASSWORD, 1'b0}, q);
      wipwait(n);
   endtask : choose_password
endmodule : host_model

// [dv/tb_top.sv]
// Self-checking bench for the sector write-protection block
module tb_top;
   import flash_protect_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PG = 8;                            // Shortened busy times
   localparam int ER = 16;
   localparam int UL = 12;
   logic        clk = 0, srst = 1, cyc, stb, we, ack, writeInProgress, programFail;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dw, dr, q;
   logic [63:0] p, pw;
   int          n_errors = 0, num_checks = 0, seed = 37568, n;
   logic [5:0]  s;
   always #12.5 clk = ~clk;
   flash_sector_write_protection #(.PAGE_CYCLES(PG), .ERASE_CYCLES(ER), .UNLOCK_CYCLES(UL))
      flash_sector_write_protection_i (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .writeInProgress(writeInProgress), .programFail(programFail));
   host_model host_model_i (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dw),
      .rdat(dr), .ack(ack), .write_in_progress(writeInProgress));
   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   // Any timed-out wait ends the run
   always @(posedge clk) begin
      if (host_model_i.hung > 0) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Expected range-code protection mask
   function automatic logic [63:0] expprot(input bit bot, input logic [2:0] r);
      int c;
      logic [63:0] m;
      c = (r == 3'h0) ? 0 : (r == 3'h7) ? 64 : (1 << (r - 1));
      m = (c == 64) ? 64'hFFFF_FFFF_FFFF_FFFF : ((64'h1 << c) - 64'h1);
      return bot ? m : (m << (64 - c));
   endfunction : expprot
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      host_model_i.xfer(1'b0, a, d, q);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_model_i.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic getprot;
      rd(ADR_PROTHI, 32'h0);
      p[63:32] = q;
      rd(ADR_PROTLO, 32'h0);
      p[31:0] = q;
   endtask : getprot
   task automatic timed(input logic [3:0] o, input logic [5:0] sc, input int exp_n, input logic fail);
      host_model_i.op(o, sc, 1);
      host_model_i.wipwait(n);
      chk("busy", n, exp_n);
      chk("fail", programFail, fail);
   endtask : timed
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rd(ADR_STATUS, 32'h0);
      chk("status", q, 32'h8);
      rd(ADR_MODE, 32'h0);
      chk("mode", q, 32'h7);
      getprot();
      chk("prot", p, 64'h0);
      for (int b = 0; b < 2; b++) begin
         for (int r = 0; r < 8; r++) begin
            wr(ADR_CTRL, (r << 2) | (b << 1));
            getprot();
            chk("range", p, expprot(b, r[2:0]));
         end
      end
      wr(ADR_CTRL, 32'h1D);
      wr(ADR_CTRL, 32'h0);
      getprot();
      chk("frozen", p, 64'hFFFF_FFFF_FFFF_FFFF);
      chk("nofail", programFail, 1'b0);
      host_model_i.op(CMD_HWRST, 6'h0, 0);
      rd(ADR_CTRL, 32'h0);
      chk("freeze", q[0], 1'b1);
      timed(CMD_OTPPROG, 6'h0, PG + 1, 1'b1);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(ADR_CTRL, 32'h0);
      chk("ctrl", q, 32'h0);
      s = 6'($random(seed));
      host_model_i.op(CMD_VCLR, s, 0);
      rd(ADR_VREAD, s);
      chk("vbyte", q[7:0], 8'h00);
      getprot();
      chk("vprot", p, 64'h1 << s);
      timed(CMD_ARRAY, s, PG + 1, 1'b1);
      host_model_i.op(CMD_VSET, s, 0);
      rd(ADR_VREAD, s);
      chk("vbyte", q[7:0], 8'hFF);
      timed(CMD_ARRAY, s, PG + 1, 1'b0);
      s = 6'($random(seed));
      timed(CMD_NVPROG, s, PG + 1, 1'b0);
      rd(ADR_NVREAD, s);
      chk("nvbyte", q[7:0], 8'h00);
      host_model_i.op(CMD_VCLR, s, 0);
      host_model_i.op(CMD_VSET, s, 0);
      getprot();
      chk("nvprot", p, 64'h1 << s);
      timed(CMD_NVERAS, 6'h0, ER + 1, 1'b0);
      rd(ADR_NVREAD, s);
      chk("nvbyte", q[7:0], 8'hFF);
      host_model_i.op(CMD_LOCKCLR, 6'h0, 0);
      rd(ADR_STATUS, 32'h0);
      chk("lock", q[3], 1'b0);
      timed(CMD_NVPROG, s, PG + 1, 1'b1);
      rd(ADR_NVREAD, s);
      chk("nvbyte", q[7:0], 8'hFF);
      host_model_i.op(CMD_HWRST, 6'h0, 0);
      rd(ADR_STATUS, 32'h0);
      chk("lock", q[3], 1'b1);
      host_model_i.op(CMD_WRITE_ENABLE_CMD, 6'h0, 0);
      wr(ADR_MODE, 32'h0);
      host_model_i.wipwait(n);
      chk("illegal", programFail, 1'b1);
      pw = {$random(seed), $random(seed)};
      host_model_i.choose_password(pw, n);
      chk("modebusy", n, PG + 1);
      host_model_i.op(CMD_WRITE_ENABLE_CMD, 6'h0, 0);
      wr(ADR_MODE, 32'h4);
      host_model_i.wipwait(n);
      rd(ADR_MODE, 32'h0);
      chk("mode", q[2:1], MODE_PASSWORD);
      host_model_i.op(CMD_HWRST, 6'h0, 0);
      rd(ADR_STATUS, 32'h0);
      chk("lock", q[3], 1'b0);
      for (int t = 0; t < 2; t++) begin
         wr(ADR_PWLO, pw[31:0] ^ (t == 0));
         wr(ADR_PWHI, pw[63:32]);
         host_model_i.op(CMD_UNLOCK, 6'h0, 0);
         host_model_i.wipwait(n);
         chk("unlockbusy", n, (t == 0) ? UL + 1 : 2);
         rd(ADR_STATUS, 32'h0);
         chk("lock", q[3], t[0]);
      end
      host_model_i.op(CMD_LOCKCLR, 6'h0, 0);
      rd(ADR_STATUS, 32'h0);
      chk("lock", q[3], 1'b0);
      stop_test();
   end
endmodule : tb_top
